// File: verilog/sms_move_seq.sv
// Move sequencer: segment loading, profile save, triggered moves and hold/resume.
//
// Functional notes
// - Pausing a dwell profile decelerates to starting speed and ends; no continue.
// - Abrupt halt command or emergency input rising edge stops motion immediately.
// - Travel-direction limit stops and blocks that direction until fault clear.
// - Rising load request sets load mode and requests the first segment.
// - Device checks segment, drops request, flags fault if the segment is bad.
// - Segment valid falling makes the device request the next segment.
// - Exchange repeats per segment; at most sixteen segments per profile.
// - Load request falling clears load mode and segment request.
// - With persist held, save profile on exit, show result, then lock.
// - Loaded profile reruns until reset, new configuration or new load.
// - Start bit picks blend or dwell; blend one direction, dwell per sign.
// - Triggered move waits for trigger input inactive-to-active edge.
// - Trigger falling edge ignored; trigger ignored while triggered move runs.
// - Command must stay until trigger; each later edge reruns the move.
// - New triggered parameters accepted only after a command bit rising edge.
// - Triggered jog stops under control when its command bit clears.
// - Pause, halt and fault clear act at once, never wait for trigger.
// - Paused jog, absolute, relative resume if no error; new rates, same target.
// - Registration move pauses to a stop but cannot continue.
// - Pausing a profile ends it; profile stays stored for reruns.
`timescale 1ns/10ps
`include "sms_params.svh"
module sms_move_seq (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Host output data image
    input wire logic host_valid,
    input wire sms_pkg::sms_host_s host,
    // Physical inputs and configuration
    input wire logic trigger_input,
    input wire logic emergency_halt_input,
    input wire logic limit_cw,
    input wire logic limit_ccw,
    input wire logic config_load,
    input wire logic [`SMS_PAR_W-1:0] start_speed,
    // Profile engine
    input wire logic eng_done,
    input wire logic eng_dir_ccw,
    input wire logic [`SMS_SEG_AW-1:0] eng_seg_addr,
    output logic eng_start,
    output logic eng_ctrl_stop,
    output logic eng_abort,
    output sms_pkg::sms_eng_s eng_cmd,
    output sms_pkg::sms_seg_s eng_seg,
    // Nonvolatile store
    input wire logic nv_done,
    input wire logic nv_ok,
    output logic nv_save_start,
    // Host input data and indicator
    output logic segment_load_mode_active,
    output logic segment_request,
    output logic command_fault_flag,
    output logic move_busy,
    output logic move_held,
    output logic trigger_armed,
    output logic cw_blocked,
    output logic ccw_blocked,
    output logic profile_ready,
    output logic op_locked,
    output logic led_green_blink,
    output logic led_red_blink
);
    typedef enum {LD_OFF, LD_WAIT_DATA, LD_WAIT_DROP, LD_SAVE, LD_LOCKED} sms_ld_e;
    typedef enum {MV_IDLE, MV_ARMED, MV_RUN, MV_HOLD} sms_mv_e;

    sms_ld_e ld;
    sms_mv_e mv;
    logic [`SMS_CTRL_W-1:0] ctrl_rise;
    logic [`SMS_CTRL_W-1:0] ctrl_fall;
    logic [1:0] pin_rise;
    logic [4:0] seg_count;
    logic persist_held;
    logic pausing;
    logic from_trigger;
    logic seg_ok;
    logic seg_wr;
    logic dir_blocked;
    logic start_ok;
    logic limit_hit;
    logic abort_now;
    logic can_resume_kind;
    logic start_now;
    logic start_err;
    logic load_err;
    sms_pkg::sms_eng_s next_cmd;

    sms_edge #(.W(`SMS_CTRL_W)) u_ctrl_edge (
        .clk(clk),
        .rst(rst),
        .sample(host_valid),
        .level({host.clear, host.halt, host.resume, host.pause, host.move_cmd, host.seg_valid, host.asm_req}),
        .rise(ctrl_rise),
        .fall(ctrl_fall)
    );

    sms_edge #(.W(2)) u_pin_edge (
        .clk(clk),
        .rst(rst),
        .sample(1'b1),
        .level({emergency_halt_input, trigger_input}),
        .rise(pin_rise),
        .fall()
    );

    sms_seg_mem u_mem (
        .clk(clk),
        .wr_en(seg_wr),
        .wr_addr(seg_count[`SMS_SEG_AW-1:0]),
        .wr_data(host.seg),
        .rd_addr(eng_seg_addr),
        .rd_data(eng_seg)
    );

    // A segment is refused when the store is full, its target is zero or it is too slow.
    assign seg_ok = (seg_count < `SMS_SEG_MAX) && (host.seg.speed >= start_speed)
                    && (host.seg.target != '0);
    assign seg_wr = (ld == LD_WAIT_DATA) && ctrl_rise[`SMS_CTRL_SEGV] && seg_ok;
    assign load_err = ((ld == LD_WAIT_DATA) && ctrl_rise[`SMS_CTRL_SEGV] && !seg_ok)
                      || (ctrl_rise[`SMS_CTRL_ASM] && (ld == LD_OFF) && (mv != MV_IDLE));

    assign dir_blocked = host.dir_ccw ? ccw_blocked : cw_blocked;
    assign start_ok = !op_locked && (ld == LD_OFF) && !dir_blocked
                      && (!(host.kind inside {sms_pkg::SMS_BLEND, sms_pkg::SMS_DWELL}) || profile_ready);

    assign limit_hit = (mv == MV_RUN) && (eng_dir_ccw ? limit_ccw : limit_cw);
    // Limits on the opposite side also stop the motor, but leave no block behind.
    assign abort_now = (mv == MV_RUN) && (ctrl_rise[`SMS_CTRL_HALT] || pin_rise[`SMS_PIN_ESTOP]
                       || limit_cw || limit_ccw);
    assign can_resume_kind = eng_cmd.kind inside {sms_pkg::SMS_JOG, sms_pkg::SMS_ABS, sms_pkg::SMS_REL};

    always_comb begin
        start_now = 1'b0;
        start_err = 1'b0;
        if (mv == MV_IDLE && ctrl_rise[`SMS_CTRL_MOVE] && !host.triggered) begin
            start_now = start_ok;
            start_err = !start_ok;
        end else if (mv == MV_ARMED && pin_rise[`SMS_PIN_TRIG] && host.move_cmd) begin
            start_now = !dir_blocked && !op_locked;
            start_err = dir_blocked || op_locked;
        end
    end

    always_comb begin
        next_cmd = eng_cmd;
        if (ctrl_rise[`SMS_CTRL_MOVE]) begin
            next_cmd.kind = host.kind;
            next_cmd.dir_ccw = host.dir_ccw;
            next_cmd.dwell = host.dwell;
            next_cmd.seg = host.seg;
            next_cmd.last_seg = 4'(seg_count - 5'h01);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ld <= LD_OFF;
            segment_load_mode_active <= 1'b0;
            segment_request <= 1'b0;
            seg_count <= 5'h00;
            persist_held <= 1'b0;
            profile_ready <= 1'b0;
            nv_save_start <= 1'b0;
            op_locked <= 1'b0;
            led_green_blink <= 1'b0;
            led_red_blink <= 1'b0;
        end else begin
            nv_save_start <= 1'b0;
            if (config_load && ld == LD_OFF) begin
                profile_ready <= 1'b0;
            end
            unique case (ld)
                LD_OFF: begin
                    if (ctrl_rise[`SMS_CTRL_ASM] && mv == MV_IDLE) begin
                        segment_load_mode_active <= 1'b1;
                        segment_request <= 1'b1;
                        seg_count <= 5'h00;
                        profile_ready <= 1'b0;
                        persist_held <= host.persist;
                        ld <= LD_WAIT_DATA;
                    end
                end
                LD_WAIT_DATA, LD_WAIT_DROP: begin
                    if (host_valid && !host.persist) begin
                        persist_held <= 1'b0;
                    end
                    if (ctrl_fall[`SMS_CTRL_ASM]) begin
                        segment_load_mode_active <= 1'b0;
                        segment_request <= 1'b0;
                        profile_ready <= seg_count != 5'h00;
                        if (persist_held && host.persist && seg_count != 5'h00) begin
                            nv_save_start <= 1'b1;
                            ld <= LD_SAVE;
                        end else begin
                            ld <= LD_OFF;
                        end
                    end else if (ld == LD_WAIT_DATA && ctrl_rise[`SMS_CTRL_SEGV]) begin
                        segment_request <= 1'b0;
                        if (seg_ok) begin
                            seg_count <= seg_count + 5'h01;
                        end
                        ld <= LD_WAIT_DROP;
                    end else if (ld == LD_WAIT_DROP && ctrl_fall[`SMS_CTRL_SEGV]) begin
                        segment_request <= 1'b1;
                        ld <= LD_WAIT_DATA;
                    end
                end
                LD_SAVE: begin
                    if (nv_done) begin
                        led_green_blink <= nv_ok;
                        led_red_blink <= !nv_ok;
                        op_locked <= 1'b1;
                        ld <= LD_LOCKED;
                    end
                end
                LD_LOCKED: begin
                    ld <= LD_LOCKED;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mv <= MV_IDLE;
            eng_start <= 1'b0;
            eng_ctrl_stop <= 1'b0;
            eng_abort <= 1'b0;
            eng_cmd <= '0;
            pausing <= 1'b0;
            from_trigger <= 1'b0;
        end else begin
            eng_start <= 1'b0;
            eng_ctrl_stop <= 1'b0;
            eng_abort <= 1'b0;
            eng_cmd <= next_cmd;
            unique case (mv)
                MV_IDLE: begin
                    if (ctrl_rise[`SMS_CTRL_MOVE] && host.triggered && !op_locked) begin
                        mv <= MV_ARMED;
                    end else if (start_now) begin
                        eng_start <= 1'b1;
                        pausing <= 1'b0;
                        from_trigger <= 1'b0;
                        mv <= MV_RUN;
                    end
                end
                MV_ARMED: begin
                    if (host_valid && !host.move_cmd) begin
                        mv <= MV_IDLE;
                    end else if (start_now) begin
                        eng_start <= 1'b1;
                        pausing <= 1'b0;
                        from_trigger <= 1'b1;
                        mv <= MV_RUN;
                    end
                end
                MV_RUN: begin
                    // The trigger pin is not read here, so it cannot restart or stop a run.
                    if (abort_now) begin
                        eng_abort <= 1'b1;
                        mv <= MV_IDLE;
                    end else if (eng_done) begin
                        if (pausing && can_resume_kind && !command_fault_flag) begin
                            mv <= MV_HOLD;
                        end else if (from_trigger && host.move_cmd && !pausing) begin
                            mv <= MV_ARMED;
                        end else begin
                            mv <= MV_IDLE;
                        end
                    end else if (!pausing && (ctrl_rise[`SMS_CTRL_PAUSE]
                                 || (eng_cmd.kind == sms_pkg::SMS_JOG && ctrl_fall[`SMS_CTRL_MOVE]))) begin
                        eng_ctrl_stop <= 1'b1;
                        pausing <= 1'b1;
                    end
                end
                MV_HOLD: begin
                    if (host_valid) begin
                        eng_cmd.seg.speed <= host.seg.speed;
                        eng_cmd.seg.accel <= host.seg.accel;
                        eng_cmd.seg.decel <= host.seg.decel;
                    end
                    if (ctrl_rise[`SMS_CTRL_HALT] || ctrl_rise[`SMS_CTRL_MOVE]) begin
                        mv <= MV_IDLE;
                    end else if (ctrl_rise[`SMS_CTRL_RESUME] && !command_fault_flag
                                 && !(eng_cmd.dir_ccw ? ccw_blocked : cw_blocked)) begin
                        eng_start <= 1'b1;
                        pausing <= 1'b0;
                        mv <= MV_RUN;
                    end
                end
            endcase
        end
    end

    // Fault flags; a new fault in the clearing cycle survives the clear.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            command_fault_flag <= 1'b0;
            cw_blocked <= 1'b0;
            ccw_blocked <= 1'b0;
        end else begin
            if (load_err || start_err || (mv == MV_HOLD && ctrl_rise[`SMS_CTRL_RESUME] && command_fault_flag)
                || (mv == MV_IDLE && ctrl_rise[`SMS_CTRL_RESUME])) begin
                command_fault_flag <= 1'b1;
            end else if (ctrl_rise[`SMS_CTRL_CLEAR]) begin
                command_fault_flag <= 1'b0;
            end
            if (limit_hit && !eng_dir_ccw) begin
                cw_blocked <= 1'b1;
            end else if (ctrl_rise[`SMS_CTRL_CLEAR]) begin
                cw_blocked <= 1'b0;
            end
            if (limit_hit && eng_dir_ccw) begin
                ccw_blocked <= 1'b1;
            end else if (ctrl_rise[`SMS_CTRL_CLEAR]) begin
                ccw_blocked <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            move_busy <= 1'b0;
            move_held <= 1'b0;
            trigger_armed <= 1'b0;
        end else begin
            move_busy <= mv == MV_RUN;
            move_held <= mv == MV_HOLD;
            trigger_armed <= mv == MV_ARMED;
        end
    end
endmodule : sms_move_seq

// File: inc/sms_params.svh
// Constants of the stepper move sequencer.
`ifndef SMS_PARAMS_SVH
`define SMS_PARAMS_SVH
`define SMS_SEG_MAX 5'h10
`define SMS_SEG_AW 4
`define SMS_POS_W 32
`define SMS_PAR_W 16
`define SMS_CTRL_W 7
`define SMS_CTRL_ASM 0
`define SMS_CTRL_SEGV 1
`define SMS_CTRL_MOVE 2
`define SMS_CTRL_PAUSE 3
`define SMS_CTRL_RESUME 4
`define SMS_CTRL_HALT 5
`define SMS_CTRL_CLEAR 6
`define SMS_PIN_TRIG 0
`define SMS_PIN_ESTOP 1
`endif

// File: inc/sms_pkg.sv
// Types of the stepper move sequencer.
`include "sms_params.svh"
package sms_pkg;
    typedef enum logic [2:0] {SMS_JOG, SMS_ABS, SMS_REL, SMS_REG, SMS_BLEND, SMS_DWELL} sms_move_e;
    typedef struct packed {
        logic signed [`SMS_POS_W-1:0] target;
        logic [`SMS_PAR_W-1:0] speed;
        logic [`SMS_PAR_W-1:0] accel;
        logic [`SMS_PAR_W-1:0] decel;
    } sms_seg_s;
    typedef struct packed {
        logic asm_req;
        logic seg_valid;
        logic persist;
        logic move_cmd;
        sms_move_e kind;
        logic triggered;
        logic dir_ccw;
        logic pause;
        logic resume;
        logic halt;
        logic clear;
        logic [`SMS_PAR_W-1:0] dwell;
        sms_seg_s seg;
    } sms_host_s;
    typedef struct packed {
        sms_move_e kind;
        logic dir_ccw;
        logic [`SMS_PAR_W-1:0] dwell;
        logic [`SMS_SEG_AW-1:0] last_seg;
        sms_seg_s seg;
    } sms_eng_s;
endpackage : sms_pkg

// File: verilog/sms_edge.sv
// Edge detector that compares each new sample with the previous one.
`timescale 1ns/10ps
module sms_edge #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Samples
    input wire logic sample,
    input wire logic [W-1:0] level,
    // Edges, valid only in the sampling cycle
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    logic [W-1:0] prev;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev <= '0;
        end else if (sample) begin
            prev <= level;
        end
    end

    assign rise = sample ? (level & ~prev) : '0;
    assign fall = sample ? (~level & prev) : '0;
endmodule : sms_edge

// File: verilog/sms_seg_mem.sv
// Profile segment store with a registered read port.
`timescale 1ns/10ps
`include "sms_params.svh"
module sms_seg_mem (
    // Clock
    input wire logic clk,
    // Write port
    input wire logic wr_en,
    input wire logic [`SMS_SEG_AW-1:0] wr_addr,
    input wire sms_pkg::sms_seg_s wr_data,
    // Read port
    input wire logic [`SMS_SEG_AW-1:0] rd_addr,
    output sms_pkg::sms_seg_s rd_data
);
    sms_pkg::sms_seg_s mem [0:(1<<`SMS_SEG_AW)-1];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule : sms_seg_mem

// File: verif/sms_host_model.sv
// Host controller model: cyclic output image and the segment loading handshake.
`timescale 1ns/10ps
module sms_host_model #(
    parameter int PER = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bench image and loading request
    input wire sms_pkg::sms_host_s img,
    input wire logic load_go,
    input wire logic [4:0] n_seg,
    input wire logic persist,
    input wire logic [15:0] spd,
    // Device side
    input wire logic segment_request,
    output logic host_valid,
    output sms_pkg::sms_host_s host,
    output logic load_done
);
    int cnt;
    logic [1:0] ld;
    logic sv;
    logic [4:0] k;
    // Images change only on send cycles, like a cyclic network.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt = 0;
            ld = 2'h0;
            sv = 1'b0;
            k = 5'h00;
            host_valid <= 1'b0;
            host <= '0;
            load_done <= 1'b0;
        end else begin
            cnt = (cnt + 1) % PER;
            host_valid <= (cnt == 0);
            if (cnt == 0) begin
                case (ld)
                    2'h0: if (load_go) begin
                        ld = 2'h1;
                        k = 5'h00;
                    end
                    2'h1: if (!sv && segment_request) begin
                        if (k == n_seg) ld = 2'h3;
                        else sv = 1'b1;
                    end else if (sv && !segment_request) begin
                        sv = 1'b0;
                        k = k + 5'h01;
                    end
                    default: begin
                        load_done <= load_go;
                        if (!load_go) ld = 2'h0;
                    end
                endcase
                host <= img;
                if (ld != 2'h0) begin
                    host.asm_req <= (ld == 2'h1);
                    host.seg_valid <= sv;
                    host.persist <= persist;
                    host.seg <= {32'(k) + 32'h1, spd, 16'h0010, 16'h0020};
                end
            end
        end
    end
endmodule : sms_host_model

// File: verif/sms_move_seq_asserts.sv
// Port assertions of the move sequencer.
`timescale 1ns/10ps
module sms_move_seq_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Inputs
    input wire logic host_valid,
    input wire sms_pkg::sms_host_s host,
    input wire logic trigger_input,
    input wire logic emergency_halt_input,
    input wire logic limit_cw,
    input wire logic limit_ccw,
    input wire logic eng_dir_ccw,
    input wire logic eng_done,
    input wire logic nv_done,
    input wire logic nv_ok,
    // Outputs
    input wire logic eng_start,
    input wire logic eng_ctrl_stop,
    input wire logic eng_abort,
    input wire logic segment_load_mode_active,
    input wire logic segment_request,
    input wire logic command_fault_flag,
    input wire logic move_busy,
    input wire logic move_held,
    input wire logic trigger_armed,
    input wire logic cw_blocked,
    input wire logic ccw_blocked,
    input wire logic op_locked,
    input wire logic led_green_blink
);
    logic [6:0] cur, prev, rise, fall;
    assign cur = {host.clear, host.halt, host.resume, host.pause, host.move_cmd, host.seg_valid, host.asm_req};
    assign rise = host_valid ? cur & ~prev : 7'h00;
    assign fall = host_valid ? ~cur & prev : 7'h00;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev <= 7'h00;
        end else if (host_valid) begin
            prev <= cur;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_load_enter: assert property (
        rise[0] && !move_busy && !move_held && !trigger_armed && !op_locked && !segment_load_mode_active
        && !eng_start |=> segment_load_mode_active && segment_request) else $error("load entry");
    a_req_drop: assert property (rise[1] && segment_request |=> !segment_request)
        else $error("request kept");
    a_req_again: assert property (
        fall[1] && host.asm_req && segment_load_mode_active |=> segment_request) else $error("no next request");
    a_load_exit: assert property (
        fall[0] && segment_load_mode_active |=> !segment_load_mode_active && !segment_request)
        else $error("load exit");
    a_halt_abort: assert property (rise[5] && move_busy |=> eng_abort) else $error("halt");
    a_estop_abort: assert property ($rose(emergency_halt_input) && move_busy |-> ##[1:4] eng_abort)
        else $error("estop");
    a_limit_block: assert property (move_busy && limit_cw && !eng_dir_ccw |-> ##[1:4] cw_blocked)
        else $error("limit");
    a_pause_stop: assert property (rise[3] && move_busy |=> eng_ctrl_stop) else $error("pause");
    a_trig_start: assert property (
        trigger_armed && host.move_cmd && $rose(trigger_input) |-> ##[1:4] eng_start) else $error("trigger");
    a_trig_ignore: assert property (
        move_busy && !eng_done && $rose(trigger_input) |=> !eng_start) else $error("retrigger");
    a_resume_go: assert property (
        rise[4] && move_held && !command_fault_flag && !cw_blocked && !ccw_blocked |=> eng_start)
        else $error("resume");
    a_save_lock: assert property (nv_done && nv_ok |=> op_locked && led_green_blink) else $error("save");
    a_lock_stays: assert property (op_locked |=> op_locked) else $error("unlock");
    a_clear_all: assert property (
        rise[6] && rise[5:0] == 6'h00 && !limit_cw && !limit_ccw
        |=> !command_fault_flag && !cw_blocked && !ccw_blocked) else $error("clear");
    c_load: cover property (fall[0] && segment_load_mode_active);
    c_resume: cover property (rise[4] && move_held);
    c_lock: cover property (nv_done);
endmodule : sms_move_seq_asserts
bind sms_move_seq sms_move_seq_asserts u_chk (.*);

// File: verif/sms_move_seq_test.sv
// Self-checking bench of the move sequencer driven through a host model.
`timescale 1ns/10ps
module sms_move_seq_test;
    logic clk, rst, trigger_input, emergency_halt_input, limit_cw, limit_ccw, config_load, eng_done;
    logic eng_dir_ccw, nv_done, nv_ok, load_go, persist, host_valid, load_done;
    logic [3:0] eng_seg_addr;
    logic [4:0] n_seg;
    logic [15:0] spd, start_speed, s0;
    sms_pkg::sms_host_s img, host;
    sms_pkg::sms_eng_s eng_cmd;
    sms_pkg::sms_seg_s eng_seg;
    logic eng_start, eng_ctrl_stop, eng_abort, nv_save_start, segment_load_mode_active, segment_request;
    logic command_fault_flag, move_busy, move_held, trigger_armed, cw_blocked, ccw_blocked;
    logic profile_ready, op_locked, led_green_blink, led_red_blink;
    logic [6:0] ev;
    int n_fail = 0, checks_done = 0, n_save = 0;
    assign ev = {load_done, trigger_armed, move_held, eng_abort, eng_ctrl_stop, eng_start, 1'b0};
    sms_move_seq dut (.*);
    sms_host_model #(.PER(4)) host_m (.*);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) eng_seg_addr <= 4'($urandom);
    always @(posedge clk) if (nv_save_start === 1'b1) n_save++;
    function automatic logic bad(int n, logic [15:0] s);
        return s < start_speed || n > 16;
    endfunction : bad
    task automatic test_done;
        if (n_fail == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wt(input int b);
        for (int t = 0; t < 2000; t++) begin
            @(negedge clk);
            if (ev[b] === 1'b1) return;
        end
        chk("wait", 1, 0);
        test_done();
    endtask : wt
    task automatic none(input int b, input int n);
        repeat (n) begin
            @(negedge clk);
            chk("quiet", 0, ev[b]);
        end
    endtask : none
    task automatic hit(input int w, input int b);
        @(posedge clk);
        {img.clear, img.halt, img.resume, img.pause} <= 4'(1 << (w - 3));
        if (b > 0) wt(b);
        else repeat (10) @(posedge clk);
        @(posedge clk);
        {img.pause, img.resume, img.halt, img.clear} <= 4'h0;
        repeat (8) @(negedge clk);
    endtask : hit
    task automatic cmd(input sms_pkg::sms_move_e k, input logic t);
        @(posedge clk);
        img.move_cmd <= 1'b0;
        repeat (8) @(posedge clk);
        {img.kind, img.triggered, img.move_cmd} <= {k, t, 1'b1};
    endtask : cmd
    task automatic fin;
        @(posedge clk);
        eng_done <= 1'b1;
        @(posedge clk);
        eng_done <= 1'b0;
        repeat (3) @(negedge clk);
    endtask : fin
    task automatic load(input int n, input logic [15:0] s, input logic p);
        @(posedge clk);
        {n_seg, spd, persist, load_go} <= {5'(n), s, p, 1'b1};
        wt(6);
        @(posedge clk);
        load_go <= 1'b0;
        repeat (2) @(negedge clk);
        chk("mode", 0, segment_load_mode_active);
        chk("request", 0, segment_request);
        chk("fault", bad(n, s), command_fault_flag);
        chk("ready", s >= start_speed, profile_ready);
        chk("save", p, n_save);
    endtask : load
    task automatic pz(input sms_pkg::sms_move_e k, input logic h);
        cmd(k, 1'b0);
        wt(1);
        hit(3, 2);
        fin();
        chk("held", h, move_held);
    endtask : pz
    task automatic rf(input sms_pkg::sms_move_e k);
        cmd(k, 1'b0);
        repeat (12) @(negedge clk);
        chk("refused", 1, command_fault_flag);
        hit(6, 0);
    endtask : rf
    task automatic tg;
        trigger_input <= 1'b1;
        wt(1);
        trigger_input <= 1'b0;
    endtask : tg
    initial begin
        void'($urandom(21718));
        rst = 1'b1;
        img = '0;
        {trigger_input, emergency_halt_input, limit_cw, limit_ccw, config_load, eng_done, eng_dir_ccw} = '0;
        {nv_done, nv_ok, load_go, persist, eng_seg_addr, n_seg, spd} = '0;
        start_speed = 16'h0100;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        load(2, 16'h00ff, 1'b0);
        hit(6, 0);
        load(17, 16'h0200, 1'b0);
        hit(6, 0);
        s0 = 16'h0100 + 16'($urandom % 512);
        load(3, s0, 1'b0);
        img.dir_ccw <= 1'($urandom);
        pz(sms_pkg::SMS_BLEND, 1'b0);
        chk("kind", sms_pkg::SMS_BLEND, eng_cmd.kind);
        chk("last", 2, eng_cmd.last_seg);
        chk("dir", img.dir_ccw, eng_cmd.dir_ccw);
        pz(sms_pkg::SMS_DWELL, 1'b0);
        @(posedge clk);
        config_load <= 1'b1;
        @(posedge clk);
        config_load <= 1'b0;
        rf(sms_pkg::SMS_BLEND);
        img.dir_ccw <= 1'b0;
        img.seg <= {32'h100, s0, 16'h0010, 16'h0010};
        pz(sms_pkg::SMS_JOG, 1'b1);
        img.seg <= {32'h55, s0 + 16'h1, 16'h0010, 16'h0010};
        hit(4, 1);
        chk("speed", s0 + 16'h1, eng_cmd.seg.speed);
        chk("target", 32'h100, eng_cmd.seg.target);
        limit_cw <= 1'b1;
        wt(3);
        repeat (3) @(negedge clk);
        chk("block", 1, cw_blocked);
        limit_cw <= 1'b0;
        rf(sms_pkg::SMS_JOG);
        chk("unblock", 0, cw_blocked);
        pz(sms_pkg::SMS_REG, 1'b0);
        hit(4, 0);
        chk("no resume", 1, command_fault_flag);
        hit(6, 0);
        cmd(sms_pkg::SMS_ABS, 1'b1);
        wt(5);
        none(1, 20);
        tg();
        repeat (3) @(posedge clk);
        trigger_input <= 1'b1;
        none(1, 10);
        trigger_input <= 1'b0;
        fin();
        wt(5);
        tg();
        fin();
        img.move_cmd <= 1'b0;
        repeat (12) @(negedge clk);
        chk("disarm", 0, trigger_armed);
        cmd(sms_pkg::SMS_JOG, 1'b1);
        wt(5);
        tg();
        img.move_cmd <= 1'b0;
        wt(2);
        fin();
        hit(5, 0);
        chk("held", 0, move_held);
        for (int i = 0; i < 4; i++) begin
            cmd(sms_pkg::sms_move_e'($urandom % 3), 1'b0);
            wt(1);
            if ($urandom % 2) begin
                emergency_halt_input <= 1'b1;
                wt(3);
                emergency_halt_input <= 1'b0;
            end else begin
                hit(5, 3);
            end
        end
        img.move_cmd <= 1'b0;
        hit(6, 0);
        load(2, s0, 1'b1);
        {nv_ok, nv_done} <= {1'($urandom), 1'b1};
        @(posedge clk);
        nv_done <= 1'b0;
        repeat (2) @(negedge clk);
        chk("green", nv_ok, led_green_blink);
        chk("red", !nv_ok, led_red_blink);
        chk("locked", 1, op_locked);
        rf(sms_pkg::SMS_JOG);
        test_done();
    end
endmodule : sms_move_seq_test
